// >>> rtl/single_step_intr.sv
// Single-step interrupt logic with vectored-interrupt priority encoder.
// Assumes CPU strobes arrive asynchronously and are synchronised here.
// Assumes port address and I/O-cycle flag come from logic on the same clock.
// Assumes strobe pulses stay low and high for at least two clocks each.
// Each strobe is acted on about three clocks after it reaches its pin.
// Address and I/O-cycle flag must still stand when the strobe is acted on.
`timescale 1ns/1ps
module single_step_intr
	import single_step_pkg::*;
#(
	parameter int          QUAL_BIT = QUAL_BIT_PRIMARY
) (
	input  wire logic              i_clk,
	input  wire logic              i_reset_n,
	input  wire logic              i_power_on_clear,
	input  wire logic [7:0]        i_port_addr,
	input  wire logic              i_io_cycle,
	input  wire logic              i_write_strobe_n,
	input  wire logic              i_status_strobe_n,
	input  wire logic              i_data_in_strobe_n,
	input  wire logic              i_int_acknowledge_status,
	input  wire logic [DATA_W-1:0] i_data_bus,
	input  wire logic [IRQ_LINES-1:0] i_irq_lines,
	output logic                   o_cpu_int,
	output logic                   o_step_int_req,
	output logic                   o_step_armed,
	output logic                   o_encoder_enable,
	output logic [DATA_W-1:0]      o_restart_opcode
);
	// ==========================================
	// Parameter check
	// Only the two qualifier positions are served
	if (QUAL_BIT != QUAL_BIT_PRIMARY && QUAL_BIT != QUAL_BIT_ALT) begin : qual_bit_check
		$error("QUAL_BIT must select bit 5 or bit 6");
	end

	// ==========================================
	// Synchronisers
	logic [4:0] sync1_r;
	logic [4:0] sync2_r;
	logic [4:0] prev_r;
	logic [DATA_W-1:0] data_s1_r;
	logic [DATA_W-1:0] data_s2_r;
	logic [IRQ_LINES-1:0] irq_s1_r;
	logic [IRQ_LINES-1:0] irq_s2_r;
	logic [4:0] async_in;
	// Strobe group packed for one capture chain
	assign async_in = {i_write_strobe_n, i_status_strobe_n, i_data_in_strobe_n,
		i_int_acknowledge_status, i_power_on_clear};

	// Idle levels of the strobe group: strobes high, levels low
	localparam logic [4:0] CTRL_IDLE = {STRB_N_RESET, STRB_N_RESET, STRB_N_RESET, SYNC_RESET, SYNC_RESET};

	// Two-flop capture of strobes, acknowledge and clear
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			sync1_r <= CTRL_IDLE;
			sync2_r <= CTRL_IDLE;
		end else begin
			sync1_r <= async_in;
			sync2_r <= sync1_r;
		end
	end

	// One-cycle history of the settled strobe group
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			prev_r <= CTRL_IDLE; // No false edge out of reset
		end else begin
			prev_r <= sync2_r;
		end
	end

	// Two-flop capture of the data bus
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			data_s1_r <= '0;
			data_s2_r <= '0;
		end else begin
			data_s1_r <= i_data_bus;
			data_s2_r <= data_s1_r;
		end
	end

	// Two-flop capture of the interrupt lines
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			irq_s1_r <= '0;
			irq_s2_r <= '0;
		end else begin
			irq_s1_r <= i_irq_lines;
			irq_s2_r <= irq_s1_r;
		end
	end

	// ==========================================
	// Edge events
	// Edges seen between history and second stage, one cycle wide
	logic wr_fall;
	logic stat_fall;
	logic din_rise;
	logic int_acknowledge_status_s;
	logic poc_s;
	logic port_hit;
	assign wr_fall   = prev_r[4] && !sync2_r[4];
	assign stat_fall = prev_r[3] && !sync2_r[3];
	assign din_rise  = !prev_r[2] && sync2_r[2];
	assign int_acknowledge_status_s    = sync2_r[1];
	assign poc_s     = sync2_r[0];
	// Address held stable by CPU during write
	assign port_hit  = i_io_cycle && i_port_addr >= STEP_PORT_FIRST
		&& i_port_addr <= STEP_PORT_LAST;

	// ==========================================
	// Arm flip-flop, inverted output kept
	// High: counter enabled and encoder disabled; low: idle
	// A port write wins over an acknowledge landing in the same cycle
	logic arm_q_n_r;
	always_ff @(posedge i_clk) begin
		if (!i_reset_n || poc_s) begin
			arm_q_n_r <= ARM_Q_RESET;
		end else if (port_hit && wr_fall) begin
			arm_q_n_r <= 1'b1;
		end else if (din_rise && int_acknowledge_status_s) begin
			arm_q_n_r <= 1'b0;
		end
	end

	// ==========================================
	// Step counter and interrupt flip-flop
	// First stage toggles per qualified strobe; its high-to-low turn sets the request
	// Disarming holds both in reset, so every arming counts from zero
	logic stage1_r;
	logic int_ff_r;
	always_ff @(posedge i_clk) begin
		if (!i_reset_n || !arm_q_n_r) begin
			stage1_r <= STAGE_RESET;
			int_ff_r <= STAGE_RESET;
		end else if (stat_fall && data_s2_r[QUAL_BIT]) begin
			stage1_r <= !stage1_r;
			if (stage1_r)
				int_ff_r <= 1'b1;
		end
	end

	// ==========================================
	// Priority encoder, highest line wins
	// Index of the highest active line, zero when none is active
	function automatic logic [2:0] encode(input logic [IRQ_LINES-1:0] lines);
		logic [2:0] idx;
		idx = '0;
		for (int i = 0; i < IRQ_LINES; i++) begin
			if (lines[i])
				idx = 3'(i);
		end
		return idx;
	endfunction

	// Encoder request, suppressed while armed
	logic enc_req;
	assign enc_req = (|irq_s2_r) && !arm_q_n_r;

	// ==========================================
	// Registered outputs
	// Processor interrupt input: encoder request or step request
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			o_cpu_int <= 1'b0;
		end else begin
			o_cpu_int <= enc_req || int_ff_r;
		end
	end

	// Single-step request as seen outside
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			o_step_int_req <= STAGE_RESET;
		end else begin
			o_step_int_req <= int_ff_r;
		end
	end

	// Arm state, one clock behind the arm flip-flop, same reset value
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			o_step_armed <= ARM_Q_RESET;
		end else begin
			o_step_armed <= arm_q_n_r;
		end
	end

	// Encoder enable, low while armed
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			o_encoder_enable <= !ARM_Q_RESET;
		end else begin
			o_encoder_enable <= !arm_q_n_r;
		end
	end

	// Restart instruction of the highest active line
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			o_restart_opcode <= RESTART_OPCODE;
		end else begin
			o_restart_opcode <= RESTART_OPCODE | {2'b00, encode(irq_s2_r), 3'b000};
		end
	end
endmodule

// >>> rtl/single_step_pkg.sv
// Constants for the single-step interrupt logic.
// Assumes a single 40 MHz system clock and synchronous reset.
package single_step_pkg;
	// ==========================================
	// Port decode
	localparam logic [7:0] STEP_PORT_FIRST = 8'h0c;
	localparam logic [7:0] STEP_PORT_LAST  = 8'h0f;
	// ==========================================
	// Encoder and bus widths
	localparam int         IRQ_LINES       = 8;
	localparam int         DATA_W          = 8;
	localparam logic [7:0] RESTART_OPCODE  = 8'hc7;
	// ==========================================
	// Reset values
	localparam logic       ARM_Q_RESET     = 1'b1;
	localparam logic       STAGE_RESET     = 1'b0;
	localparam logic       SYNC_RESET      = 1'b0;
	localparam logic       STRB_N_RESET    = 1'b1;
	// ==========================================
	// Qualifier bit positions (either one may be wired)
	localparam int         QUAL_BIT_PRIMARY = 5;
	localparam int         QUAL_BIT_ALT     = 6;
endpackage

// >>> tb/single_step_sva.sv
// Checker on the single-step block ports.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module single_step_sva(
	input wire logic       i_clk,
	input wire logic       i_reset_n,
	input wire logic       i_power_on_clear,
	input wire logic       o_cpu_int,
	input wire logic       o_step_int_req,
	input wire logic       o_step_armed,
	input wire logic       o_encoder_enable,
	input wire logic [7:0] i_irq_lines,
	input wire logic [7:0] o_restart_opcode
);
	// ====================
	// Port relations
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);
	AST_ENC: assert property (o_step_armed[*2] |-> !o_encoder_enable) else $error("enc on");
	AST_MASK: assert property ((o_step_armed && !o_step_int_req)[*5] |-> !o_cpu_int) else $error("mask");
	AST_OR: assert property (o_step_int_req |-> ##[0:1] o_cpu_int) else $error("no int");
	AST_REQ: assert property ($rose(o_step_int_req) |-> o_step_armed) else $error("req");
	AST_DROP: assert property ($fell(o_step_armed) |=> !o_step_int_req) else $error("kept");
	AST_HELD: assert property ((!o_step_armed)[*2] |-> !o_step_int_req) else $error("held");
	AST_POC: assert property (i_power_on_clear[*6] |-> o_step_armed) else $error("poc");
	AST_OPC: assert property ((i_irq_lines == 8'h10)[*5] |-> o_restart_opcode == 8'he7) else $error("opc");
endmodule
bind single_step_intr single_step_sva single_step_sva_i(.i_clk, .i_reset_n, .i_power_on_clear, .o_cpu_int,
	.o_step_int_req, .o_step_armed, .o_encoder_enable, .i_irq_lines, .o_restart_opcode);

// >>> tb/cpu_side_model.sv
// Processor-side strobe model for the single-step block.
// Assumes the bench clock; lines change at the falling edge.
`timescale 1ns/1ps
module cpu_side_model(
	input  wire logic       i_clk,
	output logic [7:0]      o_addr,
	output logic [7:0]      o_data,
	output logic            o_io,
	output logic            o_wr_n,
	output logic            o_sts_n,
	output logic            o_din_n,
	output logic            o_ack
);
	// ====================
	// Idle levels
	initial {o_addr, o_data, o_io, o_wr_n, o_sts_n, o_din_n, o_ack} = 21'h0000e;
	// One cycle: k 0 port write, 1 status, 2 acknowledge, 3 idle, 4 data-in only
	task automatic cyc_op(input int k, input logic [7:0] v);
		@(negedge i_clk) {o_addr, o_data, o_io, o_ack} = {v, v, k == 0, k == 2};
		@(negedge i_clk) {o_wr_n, o_sts_n, o_din_n} = ~((k == 4) ? 3'b001 : 3'b100 >> k);
		repeat (3) @(negedge i_clk);
		{o_wr_n, o_sts_n, o_din_n} = 3'b111;
		repeat (6) @(negedge i_clk);
		{o_addr, o_data, o_io, o_ack} = {~v, ~v, 2'b00};
	endtask
endmodule

// >>> tb/test_single_step_intr.sv
// Self-checking bench for the single-step block.
// Assumes the processor model and the bound checker.
`timescale 1ns/1ps
module test_single_step_intr;
	logic       i_clk = 1'b0, i_reset_n = 1'b0, i_power_on_clear = 1'b0, io, wr_n, sts_n, din_n, ack;
	logic       o_cpu_int, o_step_int_req, o_step_armed, o_encoder_enable;
	logic [7:0] i_irq_lines = 8'h00, addr, data, o_restart_opcode;
	int         errors = 0, cmp_count = 0, cyc = 0;
	wire  [7:0] flags = {4'h0, o_step_armed, o_encoder_enable, o_step_int_req, o_cpu_int};
	// ====================
	// Clock, partner and design
	always #12.5 i_clk = ~i_clk;
	cpu_side_model cpu_side_model_i(.i_clk, .o_addr(addr), .o_data(data), .o_io(io), .o_wr_n(wr_n),
		.o_sts_n(sts_n), .o_din_n(din_n), .o_ack(ack));
	single_step_intr single_step_intr_i(.i_clk, .i_reset_n, .i_power_on_clear, .i_port_addr(addr), .i_io_cycle(io),
		.i_write_strobe_n(wr_n), .i_status_strobe_n(sts_n), .i_data_in_strobe_n(din_n), .i_int_acknowledge_status(ack),
		.i_data_bus(data), .i_irq_lines, .o_cpu_int, .o_step_int_req, .o_step_armed, .o_encoder_enable, .o_restart_opcode);
	// Verdict and end of run
	task automatic report_and_stop();
		if (errors == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Compare one byte
	task automatic chk(input logic [7:0] got, exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Interrupt lines, one cycle, flags compare
	task automatic op(input int k, input logic [7:0] v, irq, exp);
		i_irq_lines = irq;
		cpu_side_model_i.cyc_op(k, v);
		chk(flags, exp);
	endtask
	// Hang guard
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			errors++;
			report_and_stop();
		end
	end
	// Scenarios
	initial begin
		repeat (4) @(negedge i_clk);
		i_reset_n = 1'b1;
		op(1, 8'h20, 8'h00, 8'h08);
		op(2, 8'h00, 8'h00, 8'h04);
		op(3, 8'h00, 8'h10, 8'h05);
		chk(o_restart_opcode, 8'he7);
		op(3, 8'h00, 8'h81, 8'h05);
		chk(o_restart_opcode, 8'hff);
		op(1, 8'h20, 8'h00, 8'h04);
		op(1, 8'h20, 8'h00, 8'h04);
		op(0, 8'h0b, 8'h00, 8'h04);
		op(0, 8'h0f, 8'h00, 8'h08);
		op(4, 8'h00, 8'h00, 8'h08);
		op(3, 8'h00, 8'h01, 8'h08);
		op(1, 8'hdf, 8'h00, 8'h08);
		op(1, 8'h20, 8'h00, 8'h08);
		op(1, 8'h20, 8'h00, 8'h0b);
		op(2, 8'h00, 8'h00, 8'h04);
		i_power_on_clear = 1'b1;
		op(3, 8'h00, 8'h00, 8'h08);
		report_and_stop();
	end
endmodule
